// ==== design/rpl_pixel_latch.sv ====
// Pixel latch and output level select for a triple 8-bit video converter
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Each rising edge latches 24 pixel bits into red, green, blue registers, bit 0 LSB.
// - Blanking, sync and force-white latch on the same edge as pixel data.
// - Force-white high drives all three channels to full-scale white while blanking is inactive.
// - Each data bit steers its weighted current to output when one; 00H black, FFH white.
// - Blanking inactive adds pedestal on every channel; green pedestal does not include sync current.
// - Blanking active gives blank level; separate sync current output stays on unless sync active.
// - Sync acts on separate sync current output and, while blanking is active, on level_sel (sync vs blank); red and blue unaffected.
// - All levels derive from latched blanking, sync and data each cycle.
// - While latched blanking is low, pixel data and force-white are ignored.
module rpl_pixel_latch
	import rpl_pkg::*;
#(
	parameter int unsigned WIDTH = CHAN_W
)
(
	input  wire logic             core_clk,
	input  wire logic             srst,
	input  wire logic [WIDTH-1:0] red_pixel,
	input  wire logic [WIDTH-1:0] green_pixel,
	input  wire logic [WIDTH-1:0] blue_pixel,
	input  wire logic             blank_n,
	input  wire logic             sync_n,
	input  wire logic             ref_white,
	output logic      [WIDTH-1:0] red_current_out,
	output logic      [WIDTH-1:0] green_current_out,
	output logic      [WIDTH-1:0] blue_current_out,
	output logic                  red_pedestal_on,
	output logic                  green_pedestal_on,
	output logic                  blue_pedestal_on,
	output logic                  timing_current_out,
	output var rpl_sel_t          level_sel
);

	typedef struct packed
	{
		logic [WIDTH-1:0] red;
		logic [WIDTH-1:0] green;
		logic [WIDTH-1:0] blue;
		logic             blank_n;
		logic             sync_n;
		logic             white;
	} rpl_latch_t;

	rpl_latch_t st;
	rpl_latch_t next_st;
	rpl_sel_t   kind;

	// -----------------------------------------------------------------
	// Level decode per cycle
	// -----------------------------------------------------------------
	// Blank wins over white and data, white wins over data
	function automatic rpl_sel_t level_kind(
		input logic bl_n,
		input logic sy_n,
		input logic wht
	);
		case ({bl_n, sy_n, wht})
			3'b000:
			begin
				level_kind = RPL_SEL_SYNC;
			end
			3'b001:
			begin
				level_kind = RPL_SEL_SYNC;
			end
			3'b010:
			begin
				level_kind = RPL_SEL_BLANK;
			end
			3'b011:
			begin
				level_kind = RPL_SEL_BLANK;
			end
			3'b100:
			begin
				level_kind = RPL_SEL_VIDEO;
			end
			3'b101:
			begin
				level_kind = RPL_SEL_WHITE;
			end
			3'b110:
			begin
				level_kind = RPL_SEL_VIDEO;
			end
			3'b111:
			begin
				level_kind = RPL_SEL_WHITE;
			end
			default:
			begin
				level_kind = RPL_SEL_SYNC;
			end
		endcase
	endfunction

	function automatic logic [WIDTH-1:0] chan_code(
		input rpl_sel_t         knd,
		input logic [WIDTH-1:0] data
	);
		case (knd)
			RPL_SEL_SYNC:
			begin
				chan_code = '0;
			end
			RPL_SEL_BLANK:
			begin
				chan_code = '0;
			end
			RPL_SEL_WHITE:
			begin
				chan_code = '1;
			end
			RPL_SEL_VIDEO:
			begin
				chan_code = data;
			end
			default:
			begin
				chan_code = '0;
			end
		endcase
	endfunction

	function automatic logic pedestal_on(
		input rpl_sel_t knd
	);
		case (knd)
			RPL_SEL_VIDEO:
			begin
				pedestal_on = 1'b1;
			end
			RPL_SEL_WHITE:
			begin
				pedestal_on = 1'b1;
			end
			RPL_SEL_BLANK:
			begin
				pedestal_on = 1'b0;
			end
			RPL_SEL_SYNC:
			begin
				pedestal_on = 1'b0;
			end
			default:
			begin
				pedestal_on = 1'b0;
			end
		endcase
	endfunction

	// Sync current stays separate so red and blue never carry sync
	function automatic logic sync_on(
		input logic sy_n
	);
		if (sy_n)
		begin
			sync_on = 1'b1;
		end
		else
		begin
			sync_on = 1'b0;
		end
	endfunction

	// -----------------------------------------------------------------
	// Input latch
	// -----------------------------------------------------------------
	always_comb
	begin
		next_st         = st;
		next_st.red     = red_pixel;
		next_st.green   = green_pixel;
		next_st.blue    = blue_pixel;
		next_st.blank_n = blank_n;
		next_st.sync_n  = sync_n;
		next_st.white   = ref_white;
	end

	// Reset parks outputs at sync level so nothing flashes white
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			st.red     <= '0;
			st.green   <= '0;
			st.blue    <= '0;
			st.blank_n <= RST_BLANK_N;
			st.sync_n  <= RST_SYNC_N;
			st.white   <= RST_WHITE;
		end
		else
			st <= next_st;
	end

	// -----------------------------------------------------------------
	// Level select from latched state only
	// -----------------------------------------------------------------
	always_comb
	begin
		// Decode once, shared by all three channels
		kind               = level_kind(st.blank_n, st.sync_n, st.white);
		red_current_out    = chan_code(kind, st.red);
		green_current_out  = chan_code(kind, st.green);
		blue_current_out   = chan_code(kind, st.blue);
		red_pedestal_on    = pedestal_on(kind);
		green_pedestal_on  = pedestal_on(kind);
		blue_pedestal_on   = pedestal_on(kind);
		// Sync current is independent of blanking; driver keeps sync inside blank except while no_sync holds sync low
		timing_current_out = sync_on(st.sync_n);
		level_sel          = kind;
	end

endmodule

`default_nettype wire

// ==== design/rpl_pkg.sv ====
// Package for the RGB pixel latch and level select block
package rpl_pkg;

	// -----------------------------------------------------------------
	// Widths and levels
	// -----------------------------------------------------------------
	localparam int unsigned CHAN_W     = 8;
	localparam logic [7:0]  CODE_BLACK = 8'h00;
	localparam logic [7:0]  CODE_WHITE = 8'hFF;

	// Output level word width: data code plus one bit
	localparam int unsigned LEVEL_W = CHAN_W + 1;

	// -----------------------------------------------------------------
	// Reset values of the latched controls
	// -----------------------------------------------------------------
	localparam logic RST_BLANK_N = 1'b0;
	localparam logic RST_SYNC_N  = 1'b0;
	localparam logic RST_WHITE   = 1'b0;

	// Output selection kind, visible for debug
	typedef enum logic [1:0]
	{
		RPL_SEL_SYNC  = 2'b00,
		RPL_SEL_BLANK = 2'b01,
		RPL_SEL_VIDEO = 2'b10,
		RPL_SEL_WHITE = 2'b11
	} rpl_sel_t;

	typedef struct packed
	{
		logic [CHAN_W-1:0] red;
		logic [CHAN_W-1:0] green;
		logic [CHAN_W-1:0] blue;
		logic              blank_n;
		logic              sync_n;
		logic              white;
	} rpl_state_t;

endpackage

// ==== testbench/rpl_pixel_latch_checker.sv ====
// Checker for the pixel latch output levels
`timescale 1ns/1ps
`default_nettype none
module rpl_pixel_latch_checker
	import rpl_pkg::*;
(
	input wire logic       core_clk, srst, blank_n, sync_n, ref_white,
	input wire logic [7:0] red_pixel, red_current_out, green_current_out, blue_current_out,
	input wire logic       red_pedestal_on, timing_current_out,
	input wire rpl_sel_t   level_sel
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);
	property p_dat; blank_n && !ref_white |=> red_current_out == $past(red_pixel); endproperty
	a_dat: assert property (p_dat) else $error("red code");
	property p_vid; blank_n && !ref_white |=> level_sel == RPL_SEL_VIDEO; endproperty
	a_vid: assert property (p_vid) else $error("video select");
	property p_wht; blank_n && ref_white |=> blue_current_out == 8'hFF; endproperty
	a_wht: assert property (p_wht) else $error("white code");
	property p_ped; 1 |=> red_pedestal_on == $past(blank_n); endproperty
	a_ped: assert property (p_ped) else $error("pedestal");
	property p_blk; !blank_n |=> green_current_out == 8'h00; endproperty
	a_blk: assert property (p_blk) else $error("blank code");
	property p_tim; 1 |=> timing_current_out == $past(sync_n); endproperty
	a_tim: assert property (p_tim) else $error("sync current");
	property p_syn; !blank_n && !sync_n |=> level_sel == RPL_SEL_SYNC; endproperty
	a_syn: assert property (p_syn) else $error("sync select");
	property p_bl2; !blank_n && sync_n |=> level_sel == RPL_SEL_BLANK; endproperty
	a_bl2: assert property (p_bl2) else $error("blank select");
endmodule
bind rpl_pixel_latch rpl_pixel_latch_checker u_chk (.*);
`default_nettype wire

// ==== testbench/rpl_drv.sv ====
// Pixel stream source in place of the display controller
`timescale 1ns/1ps
`default_nettype none
module rpl_drv
(
	input  wire logic       core_clk,
	input  wire logic       no_sync,
	output logic      [7:0] red_pixel, green_pixel, blue_pixel,
	output logic            blank_n, sync_n, ref_white
);
	logic [2:0] k;
	initial
	begin
		{red_pixel, green_pixel, blue_pixel, blank_n, sync_n, ref_white, k} = '0;
		// Seeded here: this is the only process that draws stimulus
		void'($urandom(32'h700AE7E7));
		forever
		begin
			@(negedge core_clk);
			k = 3'($urandom);
			{red_pixel, green_pixel, blue_pixel} <= 24'($urandom);
			blank_n <= k[2] | k[1];
			sync_n <= no_sync ? 1'b0 : |k;
			ref_white <= k[2] & k[0];
		end
	end
endmodule
`default_nettype wire

// ==== testbench/test_rgb_pixel_latch_level_select.sv ====
// Self-checking bench for the pixel latch and level select
`timescale 1ns/1ps
`default_nettype none
module test_rgb_pixel_latch_level_select;
	import rpl_pkg::*;
	logic       core_clk, srst, blank_n, sync_n, ref_white, red_pedestal_on;
	logic       green_pedestal_on, blue_pedestal_on, timing_current_out, no_sync;
	logic [7:0] red_pixel, green_pixel, blue_pixel;
	logic [7:0] red_current_out, green_current_out, blue_current_out;
	rpl_sel_t   level_sel;
	logic [29:0] q[$];
	logic [29:0] exp_v;
	int mismatches = 0;
	int compares = 0;
	wire [29:0] got = {red_current_out, green_current_out, blue_current_out, level_sel,
		red_pedestal_on, green_pedestal_on, blue_pedestal_on, timing_current_out};
	rpl_pixel_latch dut (.*);
	rpl_drv u_drv (.*);
	task automatic print_verdict;
		if (mismatches == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic check_reset;
		compares++;
		if (got !== 30'h0)
		begin
			mismatches++;
			$display("unexpected at %0t: reset levels %h", $time, got);
		end
	endtask
	initial
	begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	always @(posedge core_clk)
		if (!srst)
			q.push_back(!blank_n ? {24'h0, sync_n ? RPL_SEL_BLANK : RPL_SEL_SYNC, 3'h0, sync_n}
				: ref_white ? {24'hFFFFFF, RPL_SEL_WHITE, 3'h7, sync_n}
				: {red_pixel, green_pixel, blue_pixel, RPL_SEL_VIDEO, 3'h7, sync_n});
	always @(posedge core_clk)
	begin
		#1;
		if (q.size() > 0)
		begin
			exp_v = q.pop_front();
			compares++;
			if (got !== exp_v)
			begin
				mismatches++;
				$display("unexpected at %0t: got %h want %h", $time, got, exp_v);
			end
		end
	end
	initial
	begin
		#100000;
		mismatches++;
		print_verdict();
	end
	initial
	begin
		srst = 1'b1;
		no_sync = 1'b0;
		repeat (20) @(posedge core_clk);
		#1;
		check_reset();
		@(negedge core_clk) srst = 1'b0;
		repeat (1000) @(posedge core_clk);
		@(negedge core_clk) no_sync = 1'b1;
		repeat (500) @(posedge core_clk);
		@(negedge core_clk);
		no_sync = 1'b0;
		srst = 1'b1;
		@(posedge core_clk);
		#1;
		check_reset();
		repeat (2) @(posedge core_clk);
		@(negedge core_clk) srst = 1'b0;
		repeat (500) @(posedge core_clk);
		#2;
		print_verdict();
	end
endmodule
`default_nettype wire
